// *** hw/bdic_defines.svh ***
// constants for the bus device identity and configuration block
// assumes inclusion by bare name from the design files
`ifndef BDIC_DEFINES_SVH
`define BDIC_DEFINES_SVH
`define BDIC_CFG_REG_NUM      2'h3
`define BDIC_ID_SELFTEST      8'hff
`define BDIC_ID_ADDR_NOCOLL   8'hfe
`define BDIC_ID_ADDR_ACT      8'hfd
`define BDIC_ID_ADDR_FORCE    8'h00
`define BDIC_ID_FAILED        8'h00
`define BDIC_ADDR_LSB         8
`define BDIC_ADDR_MSB         11
`define BDIC_SRQ_BIT          13
`define BDIC_SRQ_RST          1'b1
`define BDIC_EXC_BIT          14
`define BDIC_HOST_ADDR        4'h0
`define BDIC_DEF_ADDR         4'h2
`define BDIC_DEF_ID           8'h02
`define BDIC_ALT_ID           8'h03
`define BDIC_SELFTEST_NS      1000
`define BDIC_CLK_PERIOD_NS    5
`define BDIC_SELFTEST_CYC     ((`BDIC_SELFTEST_NS + `BDIC_CLK_PERIOD_NS - 1) / `BDIC_CLK_PERIOD_NS)
`endif

// *** hw/bdic_pkg.sv ***
// types for the bus device identity and configuration block
// assumes nothing of its surroundings
package bdic_pkg;
  typedef enum logic [1:0] {
    BDIC_ST_IDLE,
    BDIC_ST_TEST,
    BDIC_ST_DONE
  } bdic_test_e;
  typedef logic [7:0] bdic_id_t;
  typedef logic [3:0] bdic_addr_t;
endpackage : bdic_pkg

// *** hw/bdic_sync.sv ***
// two flip-flop synchroniser for a pin level
// assumes one clock and an active high asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module bdic_sync (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  input  wire logic d_in,
  output var  logic q_out
);
  logic meta_reg;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_reg <= 1'b0;
      q_out    <= 1'b0;
    end else if (ce_in) begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule : bdic_sync
`default_nettype wire

// *** hw/bdic_selftest.sv ***
// self-test sequencer: runs a fixed count, then reports pass or fail
// assumes start is a one-cycle pulse on the same clock
`timescale 1ns/1ps
`default_nettype none
module bdic_selftest #(
  parameter int unsigned CYCLES = 200
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  input  wire logic start_in,
  input  wire logic fail_in,
  output var  logic busy_out,
  output var  logic failed_out
);
  bdic_pkg::bdic_test_e st_reg;
  logic [15:0]          cnt_reg;
  if (CYCLES < 1 || CYCLES > 65535) begin : g_bad_cycles
    $error("bad self-test length");
  end
  assign busy_out = (st_reg == bdic_pkg::BDIC_ST_TEST);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg     <= bdic_pkg::BDIC_ST_IDLE;
      cnt_reg    <= 16'h0000;
      failed_out <= 1'b0;
    end else if (ce_in) begin
      case (st_reg)
        bdic_pkg::BDIC_ST_IDLE, bdic_pkg::BDIC_ST_DONE: begin
          if (start_in) begin
            st_reg  <= bdic_pkg::BDIC_ST_TEST;
            cnt_reg <= 16'(CYCLES - 1);
          end
        end
        bdic_pkg::BDIC_ST_TEST: begin
          if (cnt_reg == 16'h0000) begin
            st_reg     <= bdic_pkg::BDIC_ST_DONE;
            failed_out <= fail_in;
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
        default: st_reg <= bdic_pkg::BDIC_ST_IDLE;
      endcase
    end
  end
endmodule : bdic_selftest
`default_nettype wire

// *** hw/bdic_core.sv ***
// identity and configuration register of a single-wire bus peripheral
// assumes the bit-level receiver hands over decoded register writes on this clock;
// activator, line level and bus reset pulse arrive as pins and are synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "bdic_defines.svh"
// Operation
// - holds a 4-bit default address, category code between 1 and 7
// - address zero is the host's; eight to fourteen host-assigned for relocation
// - holds an 8-bit handler identifier besides the address
// - two identifiers supported; mode output follows the selected one
// - accepted identifier is stored and reported in later register reads
// - unsupported ordinary identifier is ignored; old one keeps being reported
// - every special identifier is recognised and acted on at once
// - special identifiers are never stored as the current identifier
// - identifier 0xff starts the self-test
// - identifier 0xfe loads bits 11:8 address only if no collision seen
// - identifier 0xfd loads address only while activator is pressed
// - identifier 0x00 loads address and service-request enable bit 13 always
// - failed self-test makes the reported identifier read 0x00
// - a write changes only the fields its identifier permits; the other fields keep their values
// - layout: id 7:0, address 11:8, enable 13, event 14, 15 and 12 zero
// - line sensed low while released high during transmit is a collision
module bdic_core #(
  parameter logic [3:0]  DEF_ADDR     = `BDIC_DEF_ADDR,
  parameter logic [7:0]  DEF_ID       = `BDIC_DEF_ID,
  parameter logic [7:0]  ALT_ID       = `BDIC_ALT_ID,
  parameter int unsigned SELFTEST_CYC = `BDIC_SELFTEST_CYC
) (
  input  wire logic        REF_CLK_IN,
  input  wire logic        SYS_RST_IN,
  input  wire logic        CLK_EN_IN,
  input  wire logic        BUS_RESET_PULSE_IN,
  input  wire logic        CMD_VALID_IN,
  input  wire logic [3:0]  CMD_ADDR_IN,
  input  wire logic [1:0]  CMD_REG_IN,
  input  wire logic        CMD_WRITE_IN,
  input  wire logic [15:0] CMD_DATA_IN,
  input  wire logic        TX_ACTIVE_IN,
  input  wire logic        TX_RELEASED_IN,
  input  wire logic        LINE_PIN_IN,
  input  wire logic        ACTIVATOR_PIN_IN,
  input  wire logic        EXC_EVENT_IN,
  input  wire logic        TEST_FAIL_IN,
  output logic             CMD_HIT_OUT,
  output logic             TX_ABORT_OUT,
  output var logic [15:0]  CFG_DATA_OUT,
  output var logic [3:0]   ADDR_OUT,
  output var logic [7:0]   HANDLER_ID_OUT,
  output var logic         MODE_ALT_OUT,
  output var logic         SRQ_EN_OUT,
  output var logic         COLLISION_OUT,
  output logic             SELFTEST_BUSY_OUT
);
  logic [3:0] addr_reg;
  logic [3:0] addr_next;
  logic [7:0] id_reg;
  logic [7:0] id_next;
  logic       srq_reg;
  logic       srq_next;
  logic       coll_reg;
  logic       coll_next;
  logic       line_s;
  logic       act_s;
  logic       brst_s;
  logic       test_failed;
  logic       st_start;

  function automatic logic id_supported(input logic [7:0] id);
    id_supported = (id == DEF_ID) || (id == ALT_ID);
  endfunction : id_supported

  function automatic logic is_special_id(input logic [7:0] id);
    is_special_id = (id == `BDIC_ID_SELFTEST) || (id == `BDIC_ID_ADDR_NOCOLL) ||
                    (id == `BDIC_ID_ADDR_ACT) || (id == `BDIC_ID_ADDR_FORCE);
  endfunction : is_special_id

  // parameter checks
  if (DEF_ADDR < 4'h1 || DEF_ADDR > 4'h7) begin : g_bad_addr
    $error("default address outside 1..7");
  end
  if (is_special_id(DEF_ID)) begin : g_bad_def_id
    $error("default identifier is special");
  end
  if (is_special_id(ALT_ID)) begin : g_bad_alt_id
    $error("alternate identifier is special");
  end

  // pin synchronisers: line, activator, bus reset pulse
  wire  [2:0] pin_raw = {BUS_RESET_PULSE_IN, ACTIVATOR_PIN_IN, LINE_PIN_IN};
  logic [2:0] pin_s;
  for (genvar g = 0; g < 3; g++) begin : g_sync
    bdic_sync u_sync (
      .clk_in (REF_CLK_IN),
      .rst_in (SYS_RST_IN),
      .ce_in  (CLK_EN_IN),
      .d_in   (pin_raw[g]),
      .q_out  (pin_s[g])
    );
  end
  assign line_s = pin_s[0];
  assign act_s  = pin_s[1];
  assign brst_s = pin_s[2];

  // command decode
  wire hit        = CMD_VALID_IN && (CMD_ADDR_IN == addr_reg);
  wire cfg_wr     = hit && CMD_WRITE_IN && (CMD_REG_IN == `BDIC_CFG_REG_NUM);
  wire [7:0] w_id = CMD_DATA_IN[7:0];
  wire [3:0] w_ad = CMD_DATA_IN[`BDIC_ADDR_MSB:`BDIC_ADDR_LSB];
  wire is_test    = cfg_wr && (w_id == `BDIC_ID_SELFTEST);
  wire is_nocoll  = cfg_wr && (w_id == `BDIC_ID_ADDR_NOCOLL);
  wire is_act     = cfg_wr && (w_id == `BDIC_ID_ADDR_ACT);
  wire is_force   = cfg_wr && (w_id == `BDIC_ID_ADDR_FORCE);
  wire is_special = cfg_wr && is_special_id(w_id);
  wire id_take    = cfg_wr && !is_special && id_supported(w_id);
  wire ad_take    = (is_nocoll && !coll_reg) || (is_act && act_s) || is_force;
  wire coll_evt   = TX_ACTIVE_IN && TX_RELEASED_IN && !line_s;

  assign st_start          = is_test;
  assign CMD_HIT_OUT       = hit;
  assign TX_ABORT_OUT      = coll_evt;

  always_comb begin
    addr_next = ad_take ? w_ad : addr_reg;
    id_next   = id_take ? w_id : id_reg;
    srq_next  = is_force ? CMD_DATA_IN[`BDIC_SRQ_BIT] : srq_reg;
    // set wins over the clear from reassignment
    coll_next = coll_evt ? 1'b1 : (ad_take ? 1'b0 : coll_reg);
  end

  bdic_selftest #(
    .CYCLES (SELFTEST_CYC)
  ) u_selftest (
    .clk_in     (REF_CLK_IN),
    .rst_in     (SYS_RST_IN),
    .ce_in      (CLK_EN_IN),
    .start_in   (st_start),
    .fail_in    (TEST_FAIL_IN),
    .busy_out   (SELFTEST_BUSY_OUT),
    .failed_out (test_failed)
  );

  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      addr_reg <= DEF_ADDR;
      id_reg   <= DEF_ID;
      srq_reg  <= `BDIC_SRQ_RST;
      coll_reg <= 1'b0;
    end else if (CLK_EN_IN) begin
      if (brst_s) begin
        addr_reg <= DEF_ADDR;
        id_reg   <= DEF_ID;
        srq_reg  <= `BDIC_SRQ_RST;
        coll_reg <= 1'b0;
      end else begin
        addr_reg <= addr_next;
        id_reg   <= id_next;
        srq_reg  <= srq_next;
        coll_reg <= coll_next;
      end
    end
  end

  // reported register image
  wire [7:0]  rep_id  = test_failed ? `BDIC_ID_FAILED : id_reg;
  wire [15:0] cfg_img = {1'b0, EXC_EVENT_IN, srq_reg, 1'b0, addr_reg, rep_id};

  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      CFG_DATA_OUT   <= 16'h0000;
      ADDR_OUT       <= 4'h0;
      HANDLER_ID_OUT <= 8'h00;
      MODE_ALT_OUT   <= 1'b0;
      SRQ_EN_OUT     <= 1'b0;
      COLLISION_OUT  <= 1'b0;
    end else if (CLK_EN_IN) begin
      CFG_DATA_OUT   <= cfg_img;
      ADDR_OUT       <= addr_reg;
      HANDLER_ID_OUT <= rep_id;
      MODE_ALT_OUT   <= (id_reg == ALT_ID);
      SRQ_EN_OUT     <= srq_reg;
      COLLISION_OUT  <= coll_reg;
    end
  end

  // busy length watch for the self-test assertions
  logic [15:0] busy_len_reg;
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      busy_len_reg <= 16'h0000;
    end else if (CLK_EN_IN) begin
      busy_len_reg <= SELFTEST_BUSY_OUT ? busy_len_reg + 16'h0001 : 16'h0000;
    end
  end

  // state guards
  a_special_not_stored: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && !brst_s && is_special |=> id_reg == $past(id_reg))
    else $error("special identifier changed the stored identifier");
  a_unsupported_ignored: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && !brst_s && cfg_wr && !is_special && !id_supported(w_id)
    |=> id_reg == $past(id_reg))
    else $error("unsupported identifier was taken");
  a_id_accepted: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && !brst_s && id_take |=> id_reg == $past(w_id))
    else $error("supported identifier not stored");
  a_nocoll_guard: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && !brst_s && is_nocoll |=> addr_reg == ($past(coll_reg) ? $past(addr_reg)
                                                       : $past(w_ad)))
    else $error("collision-guarded address change wrong");
  a_activator_guard: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && !brst_s && is_act |=> addr_reg == ($past(act_s) ? $past(w_ad)
                                                    : $past(addr_reg)))
    else $error("activator-guarded address change wrong");
  a_force_load: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && !brst_s && is_force |=> addr_reg == $past(w_ad) &&
    srq_reg == $past(CMD_DATA_IN[`BDIC_SRQ_BIT]))
    else $error("unconditional load failed");
  a_selftest_start: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && is_test ##1 CLK_EN_IN |-> SELFTEST_BUSY_OUT)
    else $error("self-test did not start");
  a_bus_reset_restore: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && brst_s |=> addr_reg == DEF_ADDR && id_reg == DEF_ID && !coll_reg)
    else $error("bus reset did not restore defaults");
  a_collision_sticky: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && coll_evt && !brst_s |=> coll_reg)
    else $error("collision not recorded");
  a_reserved_zero: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    !CFG_DATA_OUT[15] && !CFG_DATA_OUT[12])
    else $error("reserved bits not zero");
  a_address_match: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CMD_HIT_OUT |-> CMD_ADDR_IN == addr_reg)
    else $error("answered a foreign address");
  a_id_legal: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    id_reg == DEF_ID || id_reg == ALT_ID)
    else $error("stored identifier is not a supported one");
  a_addr_kept: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && !brst_s && !ad_take |=> addr_reg == $past(addr_reg))
    else $error("address changed without a load");
  a_srq_kept: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && !brst_s && !is_force |=> srq_reg == $past(srq_reg))
    else $error("service-request enable changed without a load");
  a_coll_cleared: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && !brst_s && ad_take && !coll_evt |=> !coll_reg)
    else $error("collision flag not cleared by reassignment");
  a_coll_held: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && !brst_s && coll_reg && !ad_take |=> coll_reg)
    else $error("collision flag dropped without reassignment");
  a_other_reg_ignored: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && !brst_s && CMD_VALID_IN && !cfg_wr |=>
    id_reg == $past(id_reg) && addr_reg == $past(addr_reg))
    else $error("non-configuration command changed identity");
  a_freeze_state: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    !CLK_EN_IN |=> addr_reg == $past(addr_reg) && id_reg == $past(id_reg) &&
    srq_reg == $past(srq_reg) && coll_reg == $past(coll_reg))
    else $error("state moved while the clock enable was low");
  a_selftest_runs: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && SELFTEST_BUSY_OUT && busy_len_reg < 16'(SELFTEST_CYC - 1)
    |=> SELFTEST_BUSY_OUT)
    else $error("self-test ended early");
  a_selftest_ends: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && SELFTEST_BUSY_OUT && busy_len_reg == 16'(SELFTEST_CYC - 1)
    |=> !SELFTEST_BUSY_OUT)
    else $error("self-test ran too long");

  // output image guards
  a_cfg_image: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN |=> CFG_DATA_OUT[11:8] == $past(addr_reg) &&
    CFG_DATA_OUT[7:0] == $past(rep_id) && CFG_DATA_OUT[13] == $past(srq_reg) &&
    CFG_DATA_OUT[14] == $past(EXC_EVENT_IN))
    else $error("register image does not follow the state");
  a_addr_out: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN |=> ADDR_OUT == $past(addr_reg))
    else $error("address output does not follow the state");
  a_id_out: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN |=> HANDLER_ID_OUT == $past(rep_id))
    else $error("identifier output does not follow the state");
  a_failed_zero: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && test_failed |=> HANDLER_ID_OUT == `BDIC_ID_FAILED)
    else $error("failed self-test not reported");
  a_mode_out: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN |=> MODE_ALT_OUT == ($past(id_reg) == ALT_ID))
    else $error("mode output does not follow the identifier");
  a_srq_out: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN |=> SRQ_EN_OUT == $past(srq_reg))
    else $error("enable output does not follow the state");
  a_coll_out: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN |=> COLLISION_OUT == $past(coll_reg))
    else $error("collision output does not follow the flag");
endmodule : bdic_core
`default_nettype wire

// *** test/bdic_host.sv ***
// host bus controller model: issues decoded register commands to the device
// assumes the bench calls send from one process, one command at a time
`timescale 1ns/1ps
`default_nettype none
module bdic_host (
  input  wire logic        clk_in,
  input  wire logic        hit_in,
  output var  logic        valid_out,
  output var  logic [3:0]  addr_out,
  output var  logic [1:0]  reg_out,
  output var  logic        write_out,
  output var  logic [15:0] data_out
);
  initial begin
    valid_out = 1'b0;
    addr_out  = 4'h0;
    reg_out   = 2'h0;
    write_out = 1'b0;
    data_out  = 16'h0000;
  end
  // one command: held across one edge, then the lines show the inverse, not stale data
  task automatic send(input logic [3:0] a, input logic [1:0] r, input logic w,
                      input logic [15:0] d, output logic hit);
    @(posedge clk_in);
    #1;
    valid_out = 1'b1;
    addr_out  = a;
    reg_out   = r;
    write_out = w;
    data_out  = d;
    @(posedge clk_in);
    hit = hit_in;
    #1;
    valid_out = 1'b0;
    addr_out  = ~a;
    reg_out   = ~r;
    write_out = ~w;
    data_out  = ~d;
  endtask : send
endmodule : bdic_host
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench for the identity and configuration block
// assumes the host model above drives the command side
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        bus_rst = 1'b0, tx_act = 1'b0, tx_rel = 1'b0, line = 1'b1;
  logic        act = 1'b0, fail = 1'b0, hit, v, w, abort, busy, mode, srq, coll;
  logic        en = 1'b1, exc = 1'b1;
  logic [3:0]  ca, addr;
  logic [1:0]  cr;
  logic [15:0] cd, cfg;
  logic [7:0]  hid;
  int          miscompares = 0;
  int          n_compared = 0;
  localparam int ST_CYC = 4;
  always #2.5 clk = ~clk;
  bdic_host host (.clk_in(clk), .hit_in(hit), .valid_out(v), .addr_out(ca), .reg_out(cr),
                  .write_out(w), .data_out(cd));
  bdic_core #(.SELFTEST_CYC(ST_CYC)) dut (
    .REF_CLK_IN(clk), .SYS_RST_IN(rst), .CLK_EN_IN(en), .BUS_RESET_PULSE_IN(bus_rst),
    .CMD_VALID_IN(v), .CMD_ADDR_IN(ca), .CMD_REG_IN(cr), .CMD_WRITE_IN(w), .CMD_DATA_IN(cd),
    .TX_ACTIVE_IN(tx_act), .TX_RELEASED_IN(tx_rel), .LINE_PIN_IN(line),
    .ACTIVATOR_PIN_IN(act), .EXC_EVENT_IN(exc), .TEST_FAIL_IN(fail), .CMD_HIT_OUT(hit),
    .TX_ABORT_OUT(abort), .CFG_DATA_OUT(cfg), .ADDR_OUT(addr), .HANDLER_ID_OUT(hid),
    .MODE_ALT_OUT(mode), .SRQ_EN_OUT(srq), .COLLISION_OUT(coll), .SELFTEST_BUSY_OUT(busy));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // register 3 write, then let the state reach the outputs
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic exp_hit);
    logic h;
    host.send(a, 2'h3, 1'b1, d, h);
    check({15'h0, h}, {15'h0, exp_hit});
    cyc(3);
  endtask : wr
  task automatic chk_state(input logic [3:0] a, input logic [7:0] id, input logic s,
                           input logic c);
    check(cfg, {1'b0, 1'b1, s, 1'b0, a, id});
    check({12'h0, addr}, {12'h0, a});
    check({8'h0, hid}, {8'h0, id});
    check({14'h0, srq, coll}, {14'h0, s, c});
  endtask : chk_state
  task automatic t_ids;
    logic h;
    wr(4'h2, 16'h0203, 1'b1);
    chk_state(4'h2, 8'h03, 1'b1, 1'b0);
    check({15'h0, mode}, 16'h0001);
    wr(4'h2, 16'h0252, 1'b1);
    chk_state(4'h2, 8'h03, 1'b1, 1'b0);
    host.send(4'h2, 2'h1, 1'b1, 16'h0202, h);
    check({15'h0, h}, 16'h0001);
    wr(4'h5, 16'h0202, 1'b0);
    chk_state(4'h2, 8'h03, 1'b1, 1'b0);
    wr(4'h2, 16'h0202, 1'b1);
    check({15'h0, mode}, 16'h0000);
    wr(4'h2, 16'h0efe, 1'b1);
    chk_state(4'he, 8'h02, 1'b1, 1'b0);
    wr(4'h2, 16'h0203, 1'b0);
    $display("test ids and move done");
  endtask : t_ids
  task automatic t_coll;
    tx_act = 1'b1;
    tx_rel = 1'b1;
    line   = 1'b0;
    cyc(4);
    check({15'h0, abort}, 16'h0001);
    tx_act = 1'b0;
    tx_rel = 1'b0;
    line   = 1'b1;
    cyc(2);
    wr(4'he, 16'h09fe, 1'b1);
    chk_state(4'he, 8'h02, 1'b1, 1'b1);
    wr(4'he, 16'h09fd, 1'b1);
    chk_state(4'he, 8'h02, 1'b1, 1'b1);
    act = 1'b1;
    cyc(4);
    wr(4'he, 16'h09fd, 1'b1);
    chk_state(4'h9, 8'h02, 1'b1, 1'b0);
    act = 1'b0;
    wr(4'h9, 16'h0400, 1'b1);
    chk_state(4'h4, 8'h02, 1'b0, 1'b0);
    $display("test collision and address loads done");
  endtask : t_coll
  task automatic t_busrst;
    logic h;
    bus_rst = 1'b1;
    cyc(3);
    bus_rst = 1'b0;
    cyc(6);
    chk_state(4'h2, 8'h02, 1'b1, 1'b0);
    exc = 1'b0;
    cyc(2);
    check(cfg, 16'h2202);
    exc = 1'b1;
    en  = 1'b0;
    host.send(4'h2, 2'h3, 1'b1, 16'h0203, h);
    en  = 1'b1;
    check({15'h0, h}, 16'h0001);
    cyc(3);
    chk_state(4'h2, 8'h02, 1'b1, 1'b0);
    $display("test bus reset done");
  endtask : t_busrst
  task automatic t_selftest;
    int n;
    logic h;
    fail = 1'b1;
    host.send(4'h2, 2'h3, 1'b1, 16'h02ff, h);
    check({15'h0, h}, 16'h0001);
    for (n = 0; n < 10 && busy !== 1'b1; n++) cyc(1);
    check({15'h0, busy}, 16'h0001);
    for (n = 0; n < 20 && busy !== 1'b0; n++) cyc(1);
    check({15'h0, busy}, 16'h0000);
    check(16'(n), 16'(ST_CYC));
    cyc(3);
    check({8'h0, hid}, 16'h0000);
    check({8'h0, cfg[7:0]}, 16'h0000);
    fail = 1'b0;
    host.send(4'h2, 2'h3, 1'b1, 16'h02ff, h);
    for (n = 0; n < 20 && busy !== 1'b0; n++) cyc(1);
    cyc(3);
    check({8'h0, hid}, 16'h0002);
    $display("test self-test done");
  endtask : t_selftest
  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  initial begin
    cyc(6);
    rst = 1'b0;
    cyc(2);
    chk_state(4'h2, 8'h02, 1'b1, 1'b0);
    t_ids();
    t_coll();
    t_busrst();
    t_selftest();
    conclude();
  end
  initial begin
    #20000;
    miscompares++;
    conclude();
  end
endmodule : tb_top
`default_nettype wire
